//--- hw/saux_regs.sv
// Purpose: auxiliary control, interrupt status/mask, counter access, vector and
//          input/output port registers of a dual-channel serial module
// Assumes: APB slave with one wait state; pins and status synchronous to clk
// Notes:   all state frozen while ce is low
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

// Functional notes
// - input state bits follow pins only from two serial clock periods after reset
// - clear-to-send pin low when tracking starts sets its change bit
// - aux control write-only, reset zero: baud set 7, ct mode 6:4, enables 2:0
// - baud set bit selects second rate set when 1, first when 0
// - three-bit ct field picks counter or timer mode and its clock source
// - enabled change sets flags bit 7; disabled change leaves it alone
// - interrupt asserted when any flag and its mask bit are both set
// - flags read returns true values regardless of the mask
// - module reset clears every interrupt flag
// - delta-break flag sets on break start or end, stays until command
// - receiver flag mirrors fifo-full or rx-ready, picked by mode bit 6
// - transmitter flag mirrors tx-ready; writes while zero are not sent
// - mask has one enable per source, 1 enables
// - eight-bit vector number resets to 0F hex
// - input snapshot reports the six input states latched at read
// - three upper input bits without pins read one
// - output control write-only, reset zero; out3 field selects four sources
// - output control bits 7..4, 1, 0 affect no pin
// - reading the input change register clears the change flag
// - reset break-change command clears the delta-break flag of its own channel only
// - start read starts counter; stop read stops it and clears ready flag
module saux_regs
(
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               ce,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   // input pins and serial clock tick
   input  wire logic [2:0]         ip_pins,
   input  wire logic               sclk_tick,
   // channel datapaths and counter
   input  wire saux_pkg::saux_chan_t chan_a,
   input  wire saux_pkg::saux_chan_t chan_b,
   input  wire logic               ct_done,
   input  wire logic [15:0]        ct_count,
   input  wire logic               ct_out,
   // out3 sources
   input  wire logic               port_bit3,
   input  wire logic               tx_clock_b_1x,
   input  wire logic               rx_clock_b_1x,
   // interrupt acknowledge
   input  wire logic               iack,
   // control outputs
   output logic                    baud_set_select_q,
   output logic [2:0]              ct_mode_source_q,
   output logic [15:0]             preload_q,
   output logic                    ct_start_q,
   output logic                    ct_stop_q,
   output logic                    out3_q,
   output logic                    irq_q,
   output logic [7:0]              ack_vec_q,
   output logic                    ack_vec_oe_q
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0]  aux_q;
   logic [7:0]  imr_q;
   logic [7:0]  ivr_q;
   logic [1:0]  out3_sel_q;
   logic [7:0]  isr_q;
   logic [7:0]  isr_d;
   logic [2:0]  ip_state_q;
   logic [2:0]  cos_bits_q;
   logic [2:0]  cos_bits_d;
   logic [1:0]  settle_q;
   logic        tracking_q;
   logic        pready_q;
   logic [7:0]  rdata_q;
   logic        slverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode: effects take place at the completing edge only
   wire acc_first = psel & penable & ~pready_q;
   wire acc_done  = psel & penable & pready_q;
   wire wr_done   = acc_done & pwrite;
   wire rd_done   = acc_done & ~pwrite;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   wire wr_aux   = wr_done & hit(paddr, saux_pkg::OFF_AUX_CONTROL);
   wire wr_imr   = wr_done & hit(paddr, saux_pkg::OFF_INT_ENABLES);
   wire wr_ivr   = wr_done & hit(paddr, saux_pkg::OFF_IRQ_VECTOR);
   wire wr_pre_h = wr_done & hit(paddr, saux_pkg::OFF_PRELOAD_HIGH);
   wire wr_pre_l = wr_done & hit(paddr, saux_pkg::OFF_PRELOAD_LOW);
   wire wr_opcr  = wr_done & hit(paddr, saux_pkg::OFF_OUT_FUNC_SEL);
   wire wr_cmd_a = wr_done & hit(paddr, saux_pkg::OFF_CHAN_CMD_A);
   wire wr_cmd_b = wr_done & hit(paddr, saux_pkg::OFF_CHAN_CMD_B);
   wire ipcr_rd  = rd_done & hit(paddr, saux_pkg::OFF_INPUT_CHANGE);
   wire start_rd = rd_done & hit(paddr, saux_pkg::OFF_CT_START);
   wire stop_rd  = rd_done & hit(paddr, saux_pkg::OFF_CT_STOP);

   // unmapped offsets answer with an error; write-only ones read zero
   wire mapped = hit(paddr, saux_pkg::OFF_AUX_CONTROL)  | hit(paddr, saux_pkg::OFF_INT_FLAGS)
              | hit(paddr, saux_pkg::OFF_INT_ENABLES)   | hit(paddr, saux_pkg::OFF_COUNT_HIGH)
              | hit(paddr, saux_pkg::OFF_COUNT_LOW)     | hit(paddr, saux_pkg::OFF_PRELOAD_HIGH)
              | hit(paddr, saux_pkg::OFF_PRELOAD_LOW)   | hit(paddr, saux_pkg::OFF_IRQ_VECTOR)
              | hit(paddr, saux_pkg::OFF_INPUT_SNAPSHOT) | hit(paddr, saux_pkg::OFF_OUT_FUNC_SEL)
              | hit(paddr, saux_pkg::OFF_INPUT_CHANGE)  | hit(paddr, saux_pkg::OFF_CT_START)
              | hit(paddr, saux_pkg::OFF_CT_STOP)       | hit(paddr, saux_pkg::OFF_CHAN_CMD_A)
              | hit(paddr, saux_pkg::OFF_CHAN_CMD_B);

   // break-change reset command in the misc field of a channel command
   wire brk_clr_a = wr_cmd_a
                  & (pwdata[saux_pkg::CMD_MISC_HI:saux_pkg::CMD_MISC_LO] == saux_pkg::CMD_RESET_BREAK);
   wire brk_clr_b = wr_cmd_b
                  & (pwdata[saux_pkg::CMD_MISC_HI:saux_pkg::CMD_MISC_LO] == saux_pkg::CMD_RESET_BREAK);

   ////////////////////////////////////////////////////////////////////////////
   // input tracking: pins are ignored until two serial clock ticks have passed
   wire start_now = ~tracking_q & sclk_tick & (settle_q == saux_pkg::SETTLE_SCLK - 2'h1);
   // clear-to-send inputs 1:0 found low at the start count as a change
   wire [2:0] cos_start = start_now ? {1'b0, ~ip_pins[1:0]} : 3'h0;
   wire [2:0] cos_edge  = tracking_q ? (ip_pins ^ ip_state_q) : 3'h0;
   wire [2:0] cos_new   = cos_start | cos_edge;
   // only enabled inputs reach the change flag
   wire cos_int_set = |(cos_new & aux_q[saux_pkg::AUX_IEC_HI:0]);

   // sticky change bits; a new change wins over the clearing read
   assign cos_bits_d = cos_new | (cos_bits_q & ~{3{ipcr_rd}});

   ////////////////////////////////////////////////////////////////////////////
   // interrupt flags: sticky ones give priority to the set over the clear
   wire rx_a = chan_a.fifo_sel ? chan_a.fifo_full : chan_a.rx_ready;
   wire rx_b = chan_b.fifo_sel ? chan_b.fifo_full : chan_b.rx_ready;

   always_comb
   begin
      isr_d                    = 8'h00;
      isr_d[saux_pkg::ISR_COS] = cos_int_set | (isr_q[saux_pkg::ISR_COS] & ~ipcr_rd);
      isr_d[saux_pkg::ISR_DBB] = chan_b.break_change | (isr_q[saux_pkg::ISR_DBB] & ~brk_clr_b);
      isr_d[saux_pkg::ISR_RXB] = rx_b;
      isr_d[saux_pkg::ISR_TXB] = chan_b.tx_ready;
      isr_d[saux_pkg::ISR_CT]  = ct_done | (isr_q[saux_pkg::ISR_CT] & ~stop_rd);
      isr_d[saux_pkg::ISR_DBA] = chan_a.break_change | (isr_q[saux_pkg::ISR_DBA] & ~brk_clr_a);
      isr_d[saux_pkg::ISR_RXA] = rx_a;
      isr_d[saux_pkg::ISR_TXA] = chan_a.tx_ready;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data; the pin snapshot is taken in the cycle of the read
   wire [7:0] ipcr_val = {1'b0, cos_bits_q, 1'b0, ip_state_q};
   wire [7:0] snap_val = {2'b00, saux_pkg::IP_UPPER_ONES, ip_state_q};
   wire [7:0] rd_val =
        hit(paddr, saux_pkg::OFF_INT_FLAGS)      ? isr_q
      : hit(paddr, saux_pkg::OFF_INT_ENABLES)    ? imr_q
      : hit(paddr, saux_pkg::OFF_COUNT_HIGH)     ? ct_count[15:8]
      : hit(paddr, saux_pkg::OFF_COUNT_LOW)      ? ct_count[7:0]
      : hit(paddr, saux_pkg::OFF_IRQ_VECTOR)     ? ivr_q
      : hit(paddr, saux_pkg::OFF_INPUT_SNAPSHOT) ? snap_val
      : hit(paddr, saux_pkg::OFF_INPUT_CHANGE)   ? ipcr_val
      : 8'h00;

   // out3 source chosen by the stored field; other output bits are not kept
   wire out3_d = (out3_sel_q == saux_pkg::SAUX_OUT3_PORT) ? port_bit3
               : (out3_sel_q == saux_pkg::SAUX_OUT3_CT)   ? ct_out
               : (out3_sel_q == saux_pkg::SAUX_OUT3_TX_CLOCK_B) ? tx_clock_b_1x
               : rx_clock_b_1x;

   ////////////////////////////////////////////////////////////////////////////
   // apb handshake: one wait state, read data and error registered
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready_q <= 1'b0;
         rdata_q  <= 8'h00;
         slverr_q <= 1'b0;
      end
      else if (ce)
      begin
         pready_q <= acc_first;
         // error flop only rises with pready so the output needs no gate
         slverr_q <= acc_first & ~mapped;
         if (acc_first)
            rdata_q <= pwrite ? 8'h00 : rd_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software written registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aux_q      <= saux_pkg::RST_AUX_CONTROL;
         imr_q      <= saux_pkg::RST_INT_ENABLES;
         ivr_q      <= saux_pkg::RST_IRQ_VECTOR;
         out3_sel_q <= 2'h0;
         preload_q  <= 16'h0000;
      end
      else if (ce)
      begin
         if (wr_aux)
            aux_q <= pwdata[7:0];
         if (wr_imr)
            imr_q <= pwdata[7:0];
         if (wr_ivr)
            ivr_q <= pwdata[7:0];
         if (wr_opcr)
            out3_sel_q <= pwdata[saux_pkg::OUT3_HI:saux_pkg::OUT3_LO];
         // no floor enforced on the preload: software keeps it at 2 or above
         if (wr_pre_h)
            preload_q[15:8] <= pwdata[7:0];
         if (wr_pre_l)
            preload_q[7:0] <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input tracking and flags; reset clears every flag
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         settle_q   <= 2'h0;
         tracking_q <= 1'b0;
         ip_state_q <= saux_pkg::RST_IP_STATE;
         cos_bits_q <= 3'h0;
         isr_q      <= 8'h00;
      end
      else if (ce)
      begin
         if (!tracking_q && sclk_tick)
            settle_q <= settle_q + 2'h1;
         if (start_now)
            tracking_q <= 1'b1;
         if (start_now || tracking_q)
            ip_state_q <= ip_pins;
         cos_bits_q <= cos_bits_d;
         isr_q      <= isr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs: irq lags the flags by one cycle so that it comes from a flop
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_q             <= 1'b0;
         ct_start_q        <= 1'b0;
         ct_stop_q         <= 1'b0;
         out3_q            <= 1'b0;
         ack_vec_q         <= 8'h00;
         ack_vec_oe_q      <= 1'b0;
         baud_set_select_q <= 1'b0;
         ct_mode_source_q  <= 3'h0;
      end
      else if (ce)
      begin
         irq_q             <= |(isr_q & imr_q);
         ct_start_q        <= start_rd;
         ct_stop_q         <= stop_rd;
         out3_q            <= out3_d;
         ack_vec_oe_q      <= iack & irq_q;
         ack_vec_q         <= (iack & irq_q) ? ivr_q : 8'h00;
         baud_set_select_q <= aux_q[saux_pkg::AUX_BAUD_SET];
         ct_mode_source_q  <= aux_q[saux_pkg::AUX_CT_HI:saux_pkg::AUX_CT_LO];
      end
   end

   assign pready  = pready_q;
   assign prdata  = {24'h000000, rdata_q};
   assign pslverr = slverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || !ce);

   chk_track_hold: assert property (!tracking_q |-> ip_state_q == 3'h7)
      else $error("input state changed before tracking started");
   chk_cts_start: assert property (start_now && !ip_pins[0] |=> cos_bits_q[0])
      else $error("asserted cts at start did not set its change bit");
   chk_cos_gate: assert property (tracking_q && (ip_pins[1] != ip_state_q[1]) && aux_q[1]
                                  |=> isr_q[7])
      else $error("enabled input change did not set change flag");
   chk_cos_ignored: assert property (!cos_int_set && !isr_q[7] |=> !isr_q[7])
      else $error("change flag set without an enabled change");
   chk_irq_gate: assert property ((|(isr_q & imr_q)) |=> irq_q ##0 $past(imr_q) != 8'h00)
      else $error("interrupt not raised for a masked-in flag");
   chk_irq_quiet: assert property ((isr_q & imr_q) == 8'h00 |=> !irq_q)
      else $error("interrupt raised with no enabled flag");
   chk_flags_read: assert property (acc_first && !pwrite && paddr == saux_pkg::OFF_INT_FLAGS
                                    |=> pready && prdata[7:0] == $past(isr_q))
      else $error("flags read did not return true status");
   chk_break_hold: assert property (chan_a.break_change ##1 !brk_clr_a |=> isr_q[2])
      else $error("delta break a not held");
   chk_rx_mirror: assert property (chan_b.fifo_sel && chan_b.fifo_full |=> isr_q[5])
      else $error("receiver flag b not mirroring fifo full");
   chk_tx_mirror: assert property (!chan_a.tx_ready |=> !isr_q[0])
      else $error("transmitter flag a not mirroring");
   chk_ipcr_clear: assert property (ipcr_rd && !cos_int_set |=> !isr_q[7] && cos_bits_q == $past(cos_new))
      else $error("input change read did not clear change flag");
   chk_brk_cmd: assert property (brk_clr_b && !chan_b.break_change |=> !isr_q[6])
      else $error("break reset command did not clear delta break b");
   chk_stop_clear: assert property (stop_rd && !ct_done |=> !isr_q[3] && ct_stop_q)
      else $error("stop read did not clear counter ready");
   chk_vec_ack: assert property (iack && irq_q |=> ack_vec_oe_q && ack_vec_q == $past(ivr_q))
      else $error("vector not driven during acknowledge");
   chk_out3_ct: assert property (out3_sel_q == 2'h1 |=> out3_q == $past(ct_out))
      else $error("out3 not following counter output");

   cov_cos_irq: cover property (cos_int_set && imr_q[7] ##2 irq_q);
   cov_vec_ack: cover property (iack && irq_q ##1 ack_vec_oe_q);
   cov_stop_rd: cover property (isr_q[3] && stop_rd ##1 !isr_q[3]);

endmodule

//--- hw/saux_pkg.sv
// Purpose: shared constants and carriers for the serial auxiliary register set
// Assumes: 32-bit APB, one 8-bit register per aligned word, data in bits 7:0
// Notes:   byte offsets are word aligned; unused upper data bits read zero
package saux_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFF_AUX_CONTROL    = 8'h00;
   localparam logic [7:0] OFF_INT_FLAGS      = 8'h04;
   localparam logic [7:0] OFF_INT_ENABLES    = 8'h08;
   localparam logic [7:0] OFF_COUNT_HIGH     = 8'h0C;
   localparam logic [7:0] OFF_COUNT_LOW      = 8'h10;
   localparam logic [7:0] OFF_PRELOAD_HIGH   = 8'h14;
   localparam logic [7:0] OFF_PRELOAD_LOW    = 8'h18;
   localparam logic [7:0] OFF_IRQ_VECTOR     = 8'h1C;
   localparam logic [7:0] OFF_INPUT_SNAPSHOT = 8'h20;
   localparam logic [7:0] OFF_OUT_FUNC_SEL   = 8'h24;
   localparam logic [7:0] OFF_INPUT_CHANGE   = 8'h28;
   localparam logic [7:0] OFF_CT_START       = 8'h2C;
   localparam logic [7:0] OFF_CT_STOP        = 8'h30;
   localparam logic [7:0] OFF_CHAN_CMD_A     = 8'h34;
   localparam logic [7:0] OFF_CHAN_CMD_B     = 8'h38;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] RST_AUX_CONTROL  = 8'h00;
   localparam logic [7:0] RST_INT_ENABLES  = 8'h00;
   localparam logic [7:0] RST_IRQ_VECTOR   = 8'h0F;
   localparam logic [7:0] RST_OUT_FUNC_SEL = 8'h00;
   localparam logic [2:0] RST_IP_STATE     = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int AUX_BAUD_SET  = 7;
   localparam int AUX_CT_HI     = 6;
   localparam int AUX_CT_LO     = 4;
   localparam int AUX_IEC_HI    = 2;
   localparam int OUT3_HI       = 3;
   localparam int OUT3_LO       = 2;
   localparam int IPCR_COS_LO   = 4;
   localparam int CMD_MISC_HI   = 6;
   localparam int CMD_MISC_LO   = 4;
   localparam int ISR_COS       = 7;
   localparam int ISR_DBB       = 6;
   localparam int ISR_RXB       = 5;
   localparam int ISR_TXB       = 4;
   localparam int ISR_CT        = 3;
   localparam int ISR_DBA       = 2;
   localparam int ISR_RXA       = 1;
   localparam int ISR_TXA       = 0;

   ////////////////////////////////////////////////////////////////////////////
   // codes and counts
   localparam logic [2:0] CMD_RESET_BREAK  = 3'h5;
   localparam logic [2:0] IP_UPPER_ONES    = 3'h7;
   localparam logic [1:0] SETTLE_SCLK      = 2'h2;

   typedef enum logic [1:0] {
      SAUX_OUT3_PORT,
      SAUX_OUT3_CT,
      SAUX_OUT3_TX_CLOCK_B,
      SAUX_OUT3_RX_CLOCK_B
   } saux_out3_t;

   // status that one channel datapath presents to this block
   typedef struct packed {
      logic break_change;   // pulse: start or end of a received break
      logic rx_ready;       // receiver has a character
      logic fifo_full;      // receiver fifo full
      logic fifo_sel;       // first mode register bit 6
      logic tx_ready;       // holding register empty
   } saux_chan_t;

endpackage

//--- dv/saux_host.sv
// Purpose: apb master standing in for the host core on the register bus
// Assumes: one transfer at a time, called from the bench
// Notes:   waits for pready with no assumed latency; the bench watchdog ends a hang
`timescale 1ns/1ps
module saux_host
(
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   // idle bus from time zero
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one transfer; request held until pready is sampled high, released after
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

//--- dv/tb_saux_regs.sv
// Purpose: self-checking bench for the serial auxiliary register set
// Assumes: ce low only in the reset scenario; channel and counter status are plain levels
// Notes:   expectations come from the package offsets and the register layout
`timescale 1ns/1ps
module tb_saux_regs;
   logic                 clk, nrst, ce, psel, penable, pwrite, pready, pslverr, sclk_tick, ct_done;
   logic                 ct_out, port_bit3, tx_clock_b_1x, rx_clock_b_1x, iack, baud_set_select_q;
   logic                 ct_start_q, ct_stop_q, out3_q, irq_q, ack_vec_oe_q, s;
   logic [2:0]           ip_pins, ct_mode_source_q;
   logic [7:0]           paddr, ack_vec_q;
   logic [15:0]          ct_count, preload_q;
   logic [31:0]          pwdata, prdata, q;
   saux_pkg::saux_chan_t chan_a, chan_b;
   int                   err_total, checked;

   saux_regs u_dut (.clk, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .ip_pins, .sclk_tick, .chan_a, .chan_b, .ct_done, .ct_count, .ct_out, .port_bit3,
      .tx_clock_b_1x, .rx_clock_b_1x, .iack, .baud_set_select_q, .ct_mode_source_q, .preload_q,
      .ct_start_q, .ct_stop_q, .out3_q, .irq_q, .ack_vec_q, .ack_vec_oe_q);
   saux_host u_host (.clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);

   ////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic wrap_up;
      if (err_total == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
         err_total++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic e;
      u_host.xfer(1'b1, a, {24'h000000, d}, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
      logic e;
      u_host.xfer(1'b0, a, 32'h00000000, q, e);
      chk(n, exp, q);
   endtask

   // one serial clock period marker
   task automatic tick;
      sclk_tick <= 1'b1;
      @(posedge clk);
      sclk_tick <= 1'b0;
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic e;
      rd(saux_pkg::OFF_INT_ENABLES, 32'h00, "enables");
      rd(saux_pkg::OFF_IRQ_VECTOR, 32'h0F, "vector");
      rd(saux_pkg::OFF_INT_FLAGS, 32'h00, "flags");
      rd(saux_pkg::OFF_INPUT_SNAPSHOT, 32'h3F, "snapshot");
      rd(saux_pkg::OFF_AUX_CONTROL, 32'h00, "aux read");
      u_host.xfer(1'b0, 8'h3C, 32'h00000000, q, e);
      chk("slverr", 32'h1, {31'h0, e});
   endtask

   // every counter/timer code with the baud set bit toggling
   task automatic t_aux;
      for (int i = 0; i < 8; i++)
      begin
         wr(saux_pkg::OFF_AUX_CONTROL, {i[0], i[2:0], 4'h0});
         // control outputs follow the register one cycle later
         @(posedge clk);
         #1;
         chk("baud set", {31'h0, i[0]}, {31'h0, baud_set_select_q});
         chk("ct mode", i, {29'h0, ct_mode_source_q});
      end
   endtask

   // clear-to-send A held asserted across tracking start
   task automatic t_inputs;
      wr(saux_pkg::OFF_AUX_CONTROL, 8'h01);
      wr(saux_pkg::OFF_INT_ENABLES, 8'h80);
      wr(saux_pkg::OFF_IRQ_VECTOR, 8'hA5);
      rd(saux_pkg::OFF_IRQ_VECTOR, 32'hA5, "vector rw");
      ip_pins <= 3'h6;
      rd(saux_pkg::OFF_INPUT_CHANGE, 32'h07, "untracked");
      repeat (2) tick;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h80, "change flag");
      chk("irq", 32'h1, {31'h0, irq_q});
      iack <= 1'b1;
      repeat (2) @(posedge clk);
      iack <= 1'b0;
      #1;
      chk("ack vec", 32'h1A5, {23'h0, ack_vec_oe_q, ack_vec_q});
      rd(saux_pkg::OFF_INPUT_SNAPSHOT, 32'h3E, "snapshot");
      rd(saux_pkg::OFF_INPUT_CHANGE, 32'h16, "change reg");
      rd(saux_pkg::OFF_INT_FLAGS, 32'h00, "after read");
      // tracked transitions: input 2 not enabled, input 1 enabled
      wr(saux_pkg::OFF_AUX_CONTROL, 8'h02);
      ip_pins <= 3'h2;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h00, "disabled change");
      ip_pins <= 3'h0;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h80, "enabled change");
      rd(saux_pkg::OFF_INPUT_CHANGE, 32'h60, "change bits");
   endtask

   // break delta, mirrored receive and transmit flags, masking
   task automatic t_flags;
      wr(saux_pkg::OFF_INT_ENABLES, 8'h00);
      chan_a.break_change <= 1'b1;
      @(posedge clk);
      chan_a.break_change <= 1'b0;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h04, "break a");
      chk("masked irq", 32'h0, {31'h0, irq_q});
      wr(saux_pkg::OFF_CHAN_CMD_A, 8'h50);
      rd(saux_pkg::OFF_INT_FLAGS, 32'h00, "break clr");
      chan_b.fifo_sel  <= 1'b1;
      chan_b.fifo_full <= 1'b1;
      chan_a.tx_ready  <= 1'b1;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h21, "fifo sel");
      chan_b.fifo_sel <= 1'b0;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h01, "rdy sel");
      wr(saux_pkg::OFF_INT_ENABLES, 8'h01);
      repeat (2) @(posedge clk);
      chk("tx irq", 32'h1, {31'h0, irq_q});
      chan_a.tx_ready <= 1'b0;
   endtask

   task automatic t_counter;
      ct_count <= 16'h1234;
      wr(saux_pkg::OFF_PRELOAD_HIGH, 8'h01); // legal preload, both bytes seen
      wr(saux_pkg::OFF_PRELOAD_LOW, 8'h02);
      #1;
      chk("preload", 32'h0102, {16'h0000, preload_q});
      rd(saux_pkg::OFF_CT_START, 32'h00, "start");
      #1;
      s = ct_start_q;
      @(posedge clk);
      ct_done <= 1'b1;
      #1;
      chk("start pulse", 32'h2, {30'h0, s, ct_start_q});
      @(posedge clk);
      ct_done <= 1'b0;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h08, "ct ready");
      rd(saux_pkg::OFF_CT_STOP, 32'h00, "stop");
      #1;
      s = ct_stop_q;
      @(posedge clk);
      #1;
      chk("stop pulse", 32'h2, {30'h0, s, ct_stop_q});
      rd(saux_pkg::OFF_INT_FLAGS, 32'h00, "ct cleared");
      rd(saux_pkg::OFF_COUNT_HIGH, 32'h12, "count hi");   // read while stopped
      rd(saux_pkg::OFF_COUNT_LOW, 32'h34, "count lo");
   endtask

   // each out3 code with the dead bits all set
   task automatic t_out3;
      port_bit3     <= 1'b1;
      rx_clock_b_1x <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         wr(saux_pkg::OFF_OUT_FUNC_SEL, {4'hF, i[1:0], 2'h3});
         repeat (2) @(posedge clk);
         #1;
         chk("out3", (32'h9 >> i) & 32'h1, {31'h0, out3_q});
      end
      rd(saux_pkg::OFF_OUT_FUNC_SEL, 32'h00, "wo read");
   endtask

   // a pulse while ce is low is lost; then reset in mid-run with a flag pending
   task automatic t_rerun;
      ce                  <= 1'b0;
      chan_b.break_change <= 1'b1;
      @(posedge clk);
      ce                  <= 1'b1;
      chan_b.break_change <= 1'b0;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h00, "frozen");
      chan_b.break_change <= 1'b1;
      @(posedge clk);
      chan_b.break_change <= 1'b0;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h40, "break b");
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(saux_pkg::OFF_INT_FLAGS, 32'h00, "flags reset");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial
   begin
      {nrst, sclk_tick, ct_done, ct_out, port_bit3, tx_clock_b_1x, rx_clock_b_1x, iack} = '0;
      {ip_pins, ct_count, chan_a, chan_b, err_total, checked} = '0;
      ce = 1'b1;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_aux;
      t_inputs;
      t_flags;
      t_counter;
      t_out3;
      t_rerun;
      wrap_up;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      wrap_up;
   end
endmodule
